// >>> core/ptc_pkg.sv
// Shared constants and types of the periodic timer control block
`default_nettype none

package ptc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus and data widths
  localparam int unsigned PTC_ADDR_W = 8;   // Decoded low address bits
  localparam int unsigned PTC_DATA_W = 32;  // AHB-Lite data width
  localparam int unsigned PTC_CNT_W = 16;   // Counter and comparator width

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [PTC_ADDR_W-1:0] PTC_OFF_CTRL0 = 8'h00;  // Counter on/off
  localparam logic [PTC_ADDR_W-1:0] PTC_OFF_CTRL1 = 8'h04;  // timer_control_one
  localparam logic [PTC_ADDR_W-1:0] PTC_OFF_CNTL = 8'h08;   // counter_low_byte
  localparam logic [PTC_ADDR_W-1:0] PTC_OFF_CNTH = 8'h0c;   // counter_high_byte
  localparam logic [PTC_ADDR_W-1:0] PTC_OFF_CMPA = 8'h10;   // compare_a_value
  localparam logic [PTC_ADDR_W-1:0] PTC_OFF_CMPP = 8'h14;   // compare_p_value
  localparam logic [PTC_ADDR_W-1:0] PTC_OFF_STAT = 8'h18;   // Match flags

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned PTC_ON_BIT = 3;      // counter_on in control zero
  localparam int unsigned PTC_FLAG_A_BIT = 0;  // match_a_flag in status
  localparam int unsigned PTC_FLAG_P_BIT = 1;  // match_p_flag in status

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] PTC_CTRL1_RST = 8'h00;
  localparam logic [PTC_CNT_W-1:0] PTC_CNT_RST = 16'h0000;
  localparam logic [PTC_CNT_W-1:0] PTC_CMP_RST = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite encodings
  localparam logic [1:0] PTC_HTRANS_NONSEQ = 2'h2;
  localparam logic PTC_HRESP_OKAY = 1'b0;

  // Operating mode field encodings
  typedef enum logic [1:0] {
    PTC_MODE_CMP = 2'h0,    // Compare-match output
    PTC_MODE_UNDEF = 2'h1,  // Undefined
    PTC_MODE_PWM = 2'h2,    // PWM or single pulse
    PTC_MODE_TMR = 2'h3     // Timer/counter, pin unused
  } ptc_mode_e;

  // Pin function codes in compare-match mode
  localparam logic [1:0] PTC_CM_NONE = 2'h0;
  localparam logic [1:0] PTC_CM_LOW = 2'h1;
  localparam logic [1:0] PTC_CM_HIGH = 2'h2;
  localparam logic [1:0] PTC_CM_TOGGLE = 2'h3;

  // Pin function codes in PWM / single-pulse mode
  localparam logic [1:0] PTC_PW_INACT = 2'h0;
  localparam logic [1:0] PTC_PW_ACT = 2'h1;
  localparam logic [1:0] PTC_PW_PWM = 2'h2;
  localparam logic [1:0] PTC_PW_PULSE = 2'h3;

  // Layout of timer_control_one, bit 7 down to bit 0
  typedef struct packed {
    ptc_mode_e op_mode_sel;   // Bits 7:6
    logic [1:0] pin_func_sel; // Bits 5:4
    logic output_init_level;  // Bit 3
    logic output_invert;      // Bit 2
    logic reserved_zero;      // Bit 1, software writes zero
    logic clear_source_sel;   // Bit 0
  } ptc_ctrl1_s;

endpackage : ptc_pkg

`default_nettype wire

// >>> core/ptc_cmp16.sv
// One 16-bit comparator of the periodic timer
`default_nettype none

module ptc_cmp16 import ptc_pkg::*; (
  input wire logic [PTC_CNT_W-1:0] cnt,
  input wire logic [PTC_CNT_W-1:0] ref_val,
  output logic next_eq,
  output logic below
);

  // Value the counter takes on its next tick; wraps to zero past all ones
  logic [PTC_CNT_W-1:0] cnt_inc;

  assign cnt_inc = PTC_CNT_W'(cnt + 16'h0001);

  // Full-width compare, so a zero reference matches exactly on overflow
  assign next_eq = (cnt_inc == ref_val);

  // Counter still below the reference, used for the duty phase
  assign below = (cnt < ref_val);

endmodule // ptc_cmp16

`default_nettype wire

// >>> core/ptc_timer.sv
// Periodic timer control, counter and output pin with an AHB-Lite register slave
//
// Function
// [RL1] Counter-on rising edge zeroes counter, then counts
// [RL2] Counter off: stop, power down, hold value
// [RL3] Enable edge reloads pin initial level
// [RL4] Mode field bits 7:6 select operating mode
// [RL5] Software turns timer off before mode change
// [RL6] Timer/counter mode: pin unused, level bits ignored
// [RL7] Compare mode A match: none/low/high/toggle
// [RL8] PWM modes: inactive, active, PWM, single pulse
// [RL9] Requested level equal initial gives no change
// [RL10] Software changes PWM pin function only off
// [RL11] Init level bit: initial, active or pulse level
// [RL12] Invert bit set inverts the output pin
// [RL13] Software writes zero to reserved bit 1
// [RL14] Clear source: A match, else P or overflow
// [RL15] Overflow clear only with comparator P zero
// [RL16] PWM modes ignore the clear source bit
// [RL17] Counter read as low and high byte
// [RL18] Control zero bits 2:0 read zero
// [RL19] 16-bit up-counter, two full-width comparators
// [RL20] Match flags for A and P on match; no P flag while comparator A clears the counter
`default_nettype none

module ptc_timer import ptc_pkg::*; (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic count_tick,
  output logic timer_out_pin,
  output logic timer_out_pin_oe,
  output logic timer_powered,
  output logic match_a_flag,
  output logic match_p_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Bus data-phase state
  logic dp_wr_ff;                      // A write is in its data phase
  logic [PTC_ADDR_W-1:0] dp_addr_ff;   // Address of that write
  logic [PTC_DATA_W-1:0] hrdata_ff;    // Read data for the data phase

  // Software-visible state
  logic counter_on_ff;                 // Counter enable
  ptc_ctrl1_s ctrl1_ff;                // timer_control_one
  logic [PTC_CNT_W-1:0] cmp_a_ff;      // compare_a_value
  logic [PTC_CNT_W-1:0] cmp_p_ff;      // compare_p_value
  logic flag_a_ff;                     // match_a_flag, sticky
  logic flag_p_ff;                     // match_p_flag, sticky

  // Timer core state
  logic on_prev_ff;                    // counter_on one cycle ago
  logic [PTC_CNT_W-1:0] cnt_ff;        // The 16-bit up-counter
  logic out_lvl_ff;                    // Output level before inversion
  logic pin_ff;                        // Registered pin level
  logic pin_oe_ff;                     // Registered pin enable

  // Next values
  logic nxt_counter_on;
  ptc_ctrl1_s nxt_ctrl1;
  logic [PTC_CNT_W-1:0] nxt_cmp_a;
  logic [PTC_CNT_W-1:0] nxt_cmp_p;
  logic nxt_flag_a;
  logic nxt_flag_p;
  logic [PTC_CNT_W-1:0] nxt_cnt;
  logic nxt_out_lvl;
  logic nxt_pin;
  logic nxt_pin_oe;

  // Bus decode
  logic ap_take;                       // Address phase accepted
  logic ap_read;                       // Accepted phase is a read
  logic [PTC_ADDR_W-1:0] ap_addr;      // Decoded address bits
  logic [PTC_DATA_W-1:0] rd_mux;       // Read data selected by address
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_cmpa;
  logic wr_cmpp;
  logic wr_stat;

  // Core decode
  ptc_mode_e mode;
  logic on_rise;                       // counter_on went from zero to one
  logic cnt_run;                       // Counter advances this cycle
  logic a_eq;                          // Next count equals compare_a_value
  logic p_eq;                          // Next count equals compare_p_value
  logic a_below;                       // Count still below compare_a_value
  logic a_hit;                         // Comparator A match event
  logic p_hit;                         // Comparator P match event
  logic clr_by_a;                      // Counter clears on A instead of P
  logic clr_now;                       // Counter clears this tick
  logic cm_lvl;                        // Compare-mode level after an A match
  logic pw_lvl;                        // PWM-mode level this cycle
  logic a_nonzero;                     // compare_a_value is not zero

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave decode

  // Zero wait states and always OKAY; no access is ever stretched
  assign hreadyout = 1'b1;
  assign hresp = PTC_HRESP_OKAY;
  assign hrdata = hrdata_ff;

  // Only NONSEQ and SEQ transfers are taken; hsize is not checked, words only
  assign ap_take = hsel & hready & htrans[1];
  assign ap_read = ap_take & ~hwrite;
  assign ap_addr = haddr[PTC_ADDR_W-1:0];

  // Write strobes act in the data phase, when hwdata is valid
  assign wr_ctrl0 = dp_wr_ff & (dp_addr_ff == PTC_OFF_CTRL0);
  assign wr_ctrl1 = dp_wr_ff & (dp_addr_ff == PTC_OFF_CTRL1);
  assign wr_cmpa = dp_wr_ff & (dp_addr_ff == PTC_OFF_CMPA);
  assign wr_cmpp = dp_wr_ff & (dp_addr_ff == PTC_OFF_CMPP);
  assign wr_stat = dp_wr_ff & (dp_addr_ff == PTC_OFF_STAT);

  // Read data mux; unmapped addresses read zero
  always_comb begin
    rd_mux = '0;
    case (ap_addr)
      PTC_OFF_CTRL0: begin
        rd_mux[PTC_ON_BIT] = counter_on_ff;       // Bits 2:0 stay zero [RL18]
      end
      PTC_OFF_CTRL1: begin
        rd_mux[7:0] = ctrl1_ff;
      end
      PTC_OFF_CNTL: begin
        rd_mux[7:0] = cnt_ff[7:0];                // [RL17]
      end
      PTC_OFF_CNTH: begin
        rd_mux[7:0] = cnt_ff[15:8];               // [RL17]
      end
      PTC_OFF_CMPA: begin
        rd_mux[PTC_CNT_W-1:0] = cmp_a_ff;
      end
      PTC_OFF_CMPP: begin
        rd_mux[PTC_CNT_W-1:0] = cmp_p_ff;
      end
      PTC_OFF_STAT: begin
        rd_mux[PTC_FLAG_A_BIT] = flag_a_ff;
        rd_mux[PTC_FLAG_P_BIT] = flag_p_ff;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file next values

  // A new enable write takes effect one cycle after the data phase
  assign nxt_counter_on = wr_ctrl0 ? hwdata[PTC_ON_BIT] : counter_on_ff;

  // Mode changes while running are not blocked; software stops first [RL5] [RL10]
  // The reserved bit is stored as written; software keeps it zero [RL13]
  assign nxt_ctrl1 = wr_ctrl1 ? ptc_ctrl1_s'(hwdata[7:0]) : ctrl1_ff;

  assign nxt_cmp_a = wr_cmpa ? hwdata[PTC_CNT_W-1:0] : cmp_a_ff;
  assign nxt_cmp_p = wr_cmpp ? hwdata[PTC_CNT_W-1:0] : cmp_p_ff;

  // Write one to clear; a match in the same cycle wins over the clear
  assign nxt_flag_a = a_hit | (flag_a_ff & ~(wr_stat & hwdata[PTC_FLAG_A_BIT]));
  assign nxt_flag_p = (p_hit & ~clr_by_a) |
                      (flag_p_ff & ~(wr_stat & hwdata[PTC_FLAG_P_BIT])); // [RL20]

  ////////////////////////////////////////////////////////////////////////////
  // Comparators

  // Comparator A: clear, flag and pin events, plus the PWM duty phase
  ptc_cmp16 u_cmp_a (
    .cnt(cnt_ff),
    .ref_val(cmp_a_ff),
    .next_eq(a_eq),
    .below(a_below)
  ); // [RL19]

  // Comparator P: period; a zero value matches on the overflow wrap
  ptc_cmp16 u_cmp_p (
    .cnt(cnt_ff),
    .ref_val(cmp_p_ff),
    .next_eq(p_eq),
    .below()
  ); // [RL19]

  ////////////////////////////////////////////////////////////////////////////
  // Counter control

  assign mode = ctrl1_ff.op_mode_sel;                      // [RL4]
  assign on_rise = counter_on_ff & ~on_prev_ff;

  // Off means no counting at all; ticks are dropped, not stored [RL2]
  assign cnt_run = counter_on_ff & ~on_rise & count_tick;

  // A zero compare_a_value never raises an A match
  assign a_nonzero = (cmp_a_ff != PTC_CMP_RST);
  assign a_hit = cnt_run & a_eq & a_nonzero;

  // P match; with compare_p_value zero this is exactly the overflow [RL15]
  assign p_hit = cnt_run & p_eq;

  // The clear source bit only counts outside the PWM modes [RL14] [RL16]
  assign clr_by_a = ctrl1_ff.clear_source_sel & (mode != PTC_MODE_PWM);
  assign clr_now = clr_by_a ? a_hit : p_hit;                // [RL14]

  // Enable edge zeroes; a clear event loads zero instead of the increment
  always_comb begin
    nxt_cnt = cnt_ff;                                       // Hold while off [RL2]
    if (on_rise) begin
      nxt_cnt = PTC_CNT_RST;                                // [RL1]
    end else if (cnt_run) begin
      if (clr_now) begin
        nxt_cnt = PTC_CNT_RST;
      end else begin
        nxt_cnt = PTC_CNT_W'(cnt_ff + 16'h0001);            // [RL19]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output level

  // Level after an A match in compare mode; equal levels show no change [RL9]
  always_comb begin
    case (ctrl1_ff.pin_func_sel)
      PTC_CM_NONE: begin
        cm_lvl = out_lvl_ff;
      end
      PTC_CM_LOW: begin
        cm_lvl = 1'b0;
      end
      PTC_CM_HIGH: begin
        cm_lvl = 1'b1;
      end
      PTC_CM_TOGGLE: begin
        cm_lvl = ~out_lvl_ff;
      end
      default: begin
        cm_lvl = out_lvl_ff;
      end
    endcase
  end

  // Active while the count is below compare_a_value; A at or past P gives 100 %
  assign pw_lvl = a_below ? ctrl1_ff.output_init_level : ~ctrl1_ff.output_init_level;

  // Next output level per mode
  always_comb begin
    nxt_out_lvl = out_lvl_ff;
    case (mode)
      PTC_MODE_CMP: begin
        if (on_rise) begin
          nxt_out_lvl = ctrl1_ff.output_init_level;         // [RL3] [RL11]
        end else if (a_hit) begin
          nxt_out_lvl = cm_lvl;                             // [RL7]
        end
      end
      PTC_MODE_PWM: begin
        case (ctrl1_ff.pin_func_sel)
          PTC_PW_INACT: begin
            nxt_out_lvl = ~ctrl1_ff.output_init_level;      // [RL8]
          end
          PTC_PW_ACT: begin
            nxt_out_lvl = ctrl1_ff.output_init_level;       // [RL8]
          end
          PTC_PW_PWM: begin
            // Level only moves while running, so a stopped PWM freezes
            if (on_rise) begin
              nxt_out_lvl = ctrl1_ff.output_init_level;     // [RL3]
            end else if (counter_on_ff) begin
              nxt_out_lvl = pw_lvl;                         // [RL8] [RL11]
            end
          end
          PTC_PW_PULSE: begin
            // The pulse starts at enable and ends at the first A match
            if (on_rise) begin
              nxt_out_lvl = ctrl1_ff.output_init_level;     // [RL3] [RL11]
            end else if (a_hit) begin
              nxt_out_lvl = ~ctrl1_ff.output_init_level;    // [RL8]
            end
          end
          default: begin
            nxt_out_lvl = out_lvl_ff;
          end
        endcase
      end
      default: begin
        nxt_out_lvl = out_lvl_ff;                           // Level bits ignored [RL6]
      end
    endcase
  end

  // Pin is driven only in compare and PWM modes; polarity applied last
  assign nxt_pin_oe = (mode == PTC_MODE_CMP) | (mode == PTC_MODE_PWM);  // [RL6]
  assign nxt_pin = nxt_pin_oe & (out_lvl_ff ^ ctrl1_ff.output_invert); // [RL12]

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign timer_out_pin = pin_ff;
  assign timer_out_pin_oe = pin_oe_ff;
  assign timer_powered = counter_on_ff;                     // Power down when off [RL2]
  assign match_a_flag = flag_a_ff;
  assign match_p_flag = flag_p_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Flip-flops

  // Bus data-phase capture and registered read data
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dp_wr_ff <= 1'b0;
      dp_addr_ff <= '0;
      hrdata_ff <= '0;
    end else begin
      dp_wr_ff <= ap_take & hwrite;
      dp_addr_ff <= ap_addr;
      hrdata_ff <= ap_read ? rd_mux : hrdata_ff;
    end
  end

  // Software registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      counter_on_ff <= 1'b0;
      ctrl1_ff <= ptc_ctrl1_s'(PTC_CTRL1_RST);
      cmp_a_ff <= PTC_CMP_RST;
      cmp_p_ff <= PTC_CMP_RST;
      flag_a_ff <= 1'b0;
      flag_p_ff <= 1'b0;
    end else begin
      counter_on_ff <= nxt_counter_on;
      ctrl1_ff <= nxt_ctrl1;
      cmp_a_ff <= nxt_cmp_a;
      cmp_p_ff <= nxt_cmp_p;
      flag_a_ff <= nxt_flag_a;
      flag_p_ff <= nxt_flag_p;
    end
  end

  // Timer core
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      on_prev_ff <= 1'b0;
      cnt_ff <= PTC_CNT_RST;
      out_lvl_ff <= 1'b0;
      pin_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
    end else begin
      on_prev_ff <= counter_on_ff;
      cnt_ff <= nxt_cnt;
      out_lvl_ff <= nxt_out_lvl;
      pin_ff <= nxt_pin;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

endmodule // ptc_timer

`default_nettype wire

// >>> testbench/ptc_pin_load.sv
// Load on the timer output pin: a weak pull-down behind the pad
`default_nettype none
module ptc_pin_load (
  input wire logic pin,
  input wire logic oe,
  output logic pin_line
);
  timeunit 1ns;
  timeprecision 100ps;
  // An undriven pad floats to the pull-down, never to the last driven level
  assign pin_line = oe ? pin : 1'b0;
endmodule // ptc_pin_load
`default_nettype wire

// >>> testbench/ptc_timer_checker.sv
// Concurrent assertions on the ports of the periodic timer block
`default_nettype none
module ptc_timer_checker import ptc_pkg::*; (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic count_tick,
  input wire logic timer_out_pin,
  input wire logic timer_out_pin_oe,
  input wire logic timer_powered,
  input wire logic match_a_flag,
  input wire logic match_p_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  // Data-phase tracking, a shadow of control one, quiet-time counter
  logic dp_ff, dp_wr_ff;
  logic [7:0] dp_adr_ff;
  ptc_ctrl1_s ctl1_ff;
  logic [3:0] quiet_ff; // Saturates, so long idle spans stay legal
  wire logic wr_end = dp_ff && dp_wr_ff && hready;
  wire logic rd_end = dp_ff && !dp_wr_ff && hready;
  wire logic wr0 = wr_end && dp_adr_ff == PTC_OFF_CTRL0;
  wire logic wst = wr_end && dp_adr_ff == PTC_OFF_STAT;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dp_ff <= 1'b0;
      dp_wr_ff <= 1'b0;
      dp_adr_ff <= 8'h00;
      ctl1_ff <= ptc_ctrl1_s'(PTC_CTRL1_RST);
      quiet_ff <= 4'h0;
    end else begin
      if (hready) begin
        dp_ff <= hsel && htrans[1];
        dp_wr_ff <= hwrite;
        dp_adr_ff <= haddr[7:0];
      end
      if (wr_end && dp_adr_ff == PTC_OFF_CTRL1) ctl1_ff <= ptc_ctrl1_s'(hwdata[7:0]);
      quiet_ff <= (count_tick || wr_end) ? 4'h0 : quiet_ff + {3'h0, quiet_ff != 4'hf};
    end
  end
  ////////////////////////////////////////
  chk_oe_off_low: assert property (!timer_out_pin_oe |-> !timer_out_pin)
    else $error("pin high while not driven");
  chk_power_follow: assert property (wr0 |=> timer_powered == $past(hwdata[PTC_ON_BIT]))
    else $error("power state does not follow the on bit");
  chk_power_hold: assert property (!wr0 |=> $stable(timer_powered))
    else $error("power state changed without a write");
  chk_flag_a_sticky: assert property (match_a_flag && !(wst && hwdata[0]) |=> match_a_flag)
    else $error("A flag dropped without a clear");
  chk_flag_p_sticky: assert property (match_p_flag && !(wst && hwdata[1]) |=> match_p_flag)
    else $error("P flag dropped without a clear");
  chk_p_flag_src: assert property ($rose(match_p_flag) |->
    !(ctl1_ff.clear_source_sel && ctl1_ff.op_mode_sel != PTC_MODE_PWM))
    else $error("P flag raised while A clears the counter");
  chk_a_needs_tick: assert property ($rose(match_a_flag) |-> $past(count_tick) && $past(timer_powered))
    else $error("A flag raised without a counted tick");
  chk_ctrl0_read: assert property (rd_end && dp_adr_ff == PTC_OFF_CTRL0 |->
    hrdata == {28'h0, timer_powered, 3'h0})
    else $error("control zero read wrong");
  chk_ctrl1_read: assert property (rd_end && dp_adr_ff == PTC_OFF_CTRL1 |-> hrdata == {24'h0, ctl1_ff})
    else $error("control one read wrong");
  chk_pin_quiet: assert property (quiet_ff >= 4'h4 |=> $stable(timer_out_pin))
    else $error("pin moved with no tick or write");
endmodule // ptc_timer_checker
bind ptc_timer ptc_timer_checker i_ptc_timer_checker (.core_clk(core_clk), .rstn(rstn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .count_tick(count_tick), .timer_out_pin(timer_out_pin), .timer_out_pin_oe(timer_out_pin_oe),
  .timer_powered(timer_powered), .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench of the periodic timer block
`default_nettype none
module tb import ptc_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic count_tick = 1'b0;
  wire logic [31:0] hrdata;
  wire logic hready, hresp, pin, oe, powered, flag_a, flag_p, pin_line;
  int errors = 0;
  int checks_done = 0;
  logic [31:0] exp_q[$]; // Read results still owed by the bus
  logic [1:0] pin_q[$]; // Expected {oe, line} notes
  logic [15:0] lfsr = 16'h000d;
  logic [15:0] p;
  logic inv, lv0, lv1, rd_dp = 1'b0;
  int n;
  logic [7:0] offs[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h40};
  ptc_mode_e tm[2] = '{PTC_MODE_TMR, PTC_MODE_UNDEF};
  always #5 core_clk = ~core_clk;
  ptc_timer i_ptc_timer (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .count_tick(count_tick), .timer_out_pin(pin), .timer_out_pin_oe(oe),
    .timer_powered(powered), .match_a_flag(flag_a), .match_p_flag(flag_p));
  ptc_pin_load i_ptc_pin_load (.pin(pin), .oe(oe), .pin_line(pin_line));
  ////////////////////////////////////////
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One single AHB-Lite transfer; each phase held until hready is seen
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= PTC_HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic cnt(input logic [15:0] e);
    rd(PTC_OFF_CNTL, {24'h0, e[7:0]});
    rd(PTC_OFF_CNTH, {24'h0, e[15:8]});
  endtask
  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge core_clk);
      count_tick <= 1'b1;
    end
    @(posedge core_clk);
    count_tick <= 1'b0;
  endtask
  // Pin settles a cycle after its level register, so allow a few edges
  task automatic expect_pin(input logic o, input logic v);
    repeat (4) @(posedge core_clk);
    pin_q.push_back({o, v});
  endtask
  // Timer is switched off before mode and pin function change
  task automatic run(input logic [7:0] c, input logic [15:0] a, input logic [15:0] pv);
    wr(PTC_OFF_CTRL0, 32'h0);
    wr(PTC_OFF_CMPA, {16'h0, a});
    wr(PTC_OFF_CMPP, {16'h0, pv});
    wr(PTC_OFF_CTRL1, {24'h0, c[7:2], 1'b0, c[0]});
    wr(PTC_OFF_STAT, 32'h3);
    wr(PTC_OFF_CTRL0, 32'h8);
    repeat (2) @(posedge core_clk);
  endtask
  ////////////////////////////////////////
  // Result watchers: bus read data, then pin level
  always @(posedge core_clk) begin
    if (rd_dp && hready === 1'b1) cmp32(hrdata, exp_q.pop_front());
    // Every read data phase must also end with an OKAY response
    if (rd_dp && hready === 1'b1) cmp32({31'h0, hresp}, {31'h0, PTC_HRESP_OKAY});
    rd_dp = hsel && hready && htrans[1] && !hwrite;
  end
  always @(negedge core_clk) begin
    while (pin_q.size() > 0) cmp32({30'h0, oe, pin_line}, {30'h0, pin_q.pop_front()});
  end
  initial begin
    // The long overflow count dominates; about 66300 cycles in all
    repeat (80000) @(posedge core_clk);
    errors++;
    close_out();
  end
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    foreach (offs[i]) rd(offs[i], 32'h0);
    // Reset mode is compare-match, so the pin is driven at its low initial level
    expect_pin(1'b1, 1'b0);
    wr(PTC_OFF_CTRL0, 32'hff);
    rd(PTC_OFF_CTRL0, 32'h8);
    wr(PTC_OFF_CTRL0, 32'h0);
    lfsr = lfsr_next(lfsr);
    wr(PTC_OFF_CTRL1, {24'h0, lfsr[7:2], 1'b0, lfsr[0]});
    rd(PTC_OFF_CTRL1, {24'h0, lfsr[7:2], 1'b0, lfsr[0]});
    wr(PTC_OFF_CNTL, 32'hff);
    cnt(16'h0);
    // Counting, hold while off, restart from zero; pin unused
    foreach (tm[i]) begin
      lfsr = lfsr_next(lfsr);
      p = 16'h8 + {12'h0, lfsr[3:0]};
      n = 24 + int'(lfsr[9:4]);
      run({tm[i], 2'h3, 1'b1, 1'b1, 2'h0}, 16'h7, p);
      ticks(n);
      cnt(16'(n % p));
      expect_pin(1'b0, 1'b0);
      wr(PTC_OFF_CTRL0, 32'h0);
      ticks(5);
      cnt(16'(n % p));
      rd(PTC_OFF_STAT, 32'h3);
      wr(PTC_OFF_STAT, 32'h1);
      rd(PTC_OFF_STAT, 32'h2);
      wr(PTC_OFF_CTRL0, 32'h8);
      cnt(16'h0);
    end
    run({PTC_MODE_TMR, 4'h0, 2'h0}, 16'h0, 16'h0);
    ticks(300);
    cnt(16'h012c);
    ticks(65238);
    cnt(16'h0002);
    run({PTC_MODE_CMP, 5'h0, 1'b1}, 16'h7, 16'h3);
    ticks(10);
    cnt(16'h3);
    rd(PTC_OFF_STAT, 32'h1);
    run({PTC_MODE_PWM, PTC_PW_PWM, 3'h4, 1'b1}, 16'h4, 16'ha);
    expect_pin(1'b1, 1'b1);
    ticks(15);
    cnt(16'h5);
    expect_pin(1'b1, 1'b0);
    run({PTC_MODE_PWM, PTC_PW_PULSE, 4'h4}, 16'h3, 16'h0);
    expect_pin(1'b1, 1'b1);
    ticks(3);
    expect_pin(1'b1, 1'b0);
    // Every pin code of compare mode and the forced PWM levels
    for (int m = 0; m < 2; m++) for (int f = 0; f < 4; f++) for (int o = 0; o < 2; o++) if (m == 0 || f < 2) begin
      lfsr = lfsr_next(lfsr);
      inv = lfsr[0];
      run({m[0] ? PTC_MODE_PWM : PTC_MODE_CMP, f[1:0], o[0], inv, 2'h1}, 16'h4, 16'h0);
      lv0 = (m == 1 && f == 0) ? !o[0] : o[0];
      expect_pin(1'b1, lv0 ^ inv);
      ticks(4);
      lv1 = (m == 1) ? lv0 : (f == 0) ? o[0] : (f == 3) ? !o[0] : f[1];
      expect_pin(1'b1, lv1 ^ inv);
    end
    repeat (2) @(posedge core_clk);
    close_out();
  end
endmodule // tb
`default_nettype wire
